// >>> inc/tli_pkg.sv
// Overview of operation
// - a secondary flag latches to one on its event and stays set
// - writing one to a secondary flag clears it, zero leaves it
// - reading a secondary flag register never alters any flag
// - each primary flag is the OR of its unmasked secondary flags
// - every secondary flag has its own mask toward its primary flag
// - primary status register is read-only, writes have no effect
// - alert output is low when any enabled primary flag is set
// - every primary flag has its own mask toward the alert output
// - type bit one gives open drain, zero gives push-pull drive
// - global alert mask set keeps the alert pin high or released
// - secondary flags latch whatever their own mask setting
// - primary flags follow secondaries whatever the alert masks
// - non-interrupt actions are carried out regardless of any mask
// - a primary flag falls only when its secondaries are cleared or masked
// - after reset every primary-to-alert mask bit is set
// - primary bits 15..11 power, thermal, gpio, on-pin, watchdog; 8 converter; 7 path
package tli_pkg;
  // ==========================================================
  // widths
  localparam int PADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int IDX_W = PADDR_W - 2;
  localparam int NUM_PRI = 7;
  localparam int SEC_W = 4;
  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PRI_STATUS = 18'h04010;
  localparam logic [IDX_W-1:0] IDX_ALERT_CFG = 18'h04017;
  localparam logic [IDX_W-1:0] IDX_PRI_MASK = 18'h04018;
  localparam logic [IDX_W-1:0] IDX_SEC_FLAG_BASE = 18'h04020;
  localparam logic [IDX_W-1:0] IDX_SEC_MASK_BASE = 18'h04028;
  // ==========================================================
  // field positions
  localparam int PRI_POS [NUM_PRI] = '{15, 14, 13, 12, 11, 8, 7};
  localparam int CFG_GMASK_BIT = 0;
  localparam int CFG_OD_BIT = 1;
  localparam int CFG_PIN_BIT = 2;
  // ==========================================================
  // reset values
  localparam logic [NUM_PRI-1:0] PRI_MASK_RST = 7'h7f;
  localparam logic [SEC_W-1:0] SEC_MASK_RST = 4'h0;
  localparam logic [SEC_W-1:0] SEC_FLAG_RST = 4'h0;
  localparam logic CFG_OD_RST = 1'h0;
  localparam logic CFG_GMASK_RST = 1'h0;
  localparam logic ALERT_OUT_RST = 1'h1;
  localparam logic ALERT_OEN_RST = 1'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
endpackage

// >>> hdl/tli_sec_group.sv
`timescale 1ns/1ns
`default_nettype none
module tli_sec_group
  import tli_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // event sources
  input wire logic [SEC_W-1:0] eventIn,
  // register access
  input wire logic clrWe,
  input wire logic [SEC_W-1:0] clrData,
  input wire logic maskWe,
  input wire logic [SEC_W-1:0] maskData,
  input wire logic [SEC_W-1:0] maskLane,
  // state out
  output logic [SEC_W-1:0] flags,
  output logic [SEC_W-1:0] mask,
  output logic primary
);
  typedef struct packed {
    logic [SEC_W-1:0] flags;
    logic [SEC_W-1:0] mask;
  } tli_sec_state_t;

  tli_sec_state_t st_q, st_d;

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    if (ce) begin
      // event set wins over a clear in the same cycle
      if (clrWe) begin
        st_d.flags = st_q.flags & ~clrData;
      end
      st_d.flags = st_d.flags | eventIn;
      if (maskWe) begin
        st_d.mask = (st_q.mask & ~maskLane) | (maskData & maskLane);
      end
    end
  end

  // single clock, defaults on reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{flags: SEC_FLAG_RST, mask: SEC_MASK_RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;
  assign mask = st_q.mask;
  // primary drops only when nothing unmasked is left
  assign primary = |(st_q.flags & ~st_q.mask);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence evtSeen;
    ce && (eventIn != 4'h0);
  endsequence
  sequence quietTwo;
    (!clrWe)[*2];
  endsequence

  event_latch_a: assert property (evtSeen |=>
    ((flags & $past(eventIn)) == $past(eventIn)))
    else $error("event did not latch its flag");
  flag_sticky_a: assert property (evtSeen ##1 quietTwo |->
    ((flags & $past(eventIn, 2)) == $past(eventIn, 2)))
    else $error("latched flag fell without a clear");
  clear_one_a: assert property (ce && clrWe && eventIn == 4'h0 |=>
    flags == ($past(flags) & ~$past(clrData)))
    else $error("write-one clear misbehaved");
  set_wins_a: assert property (ce && clrWe && ((eventIn & clrData) != 4'h0) |=>
    ((flags & $past(eventIn)) == $past(eventIn)))
    else $error("event lost against a clear");
  masked_latch_a: assert property (ce && ((eventIn & mask) != 4'h0) |=>
    ((flags & $past(eventIn & mask)) != 4'h0))
    else $error("masked event not latched");
  primary_fall_a: assert property ($fell(primary) |->
    ((flags & ~mask) == 4'h0) && ($past(clrWe) || $past(maskWe)))
    else $error("primary fell with unmasked flag left");
endmodule // tli_sec_group
`default_nettype wire

// >>> hdl/tli_ctrl.sv
// The APB register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module tli_ctrl
  import tli_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [DATA_W-1:0] prdata,
  // secondary events, one group per primary flag
  input wire logic [SEC_W-1:0] powerStateEvt,
  input wire logic [SEC_W-1:0] thermalEvt,
  input wire logic [SEC_W-1:0] gpioEvt,
  input wire logic [SEC_W-1:0] onPinEvt,
  input wire logic [SEC_W-1:0] watchdogEvt,
  input wire logic [SEC_W-1:0] auxConverterEvt,
  input wire logic [SEC_W-1:0] powerPathEvt,
  // non-interrupt action, such as a watchdog reset
  input wire logic actionReq,
  output logic actionOut,
  // alert pin, active low, oen low while driving
  input wire logic alertPinIn,
  output logic alertOut,
  output logic alertOen
);
  typedef struct packed {
    logic [NUM_PRI-1:0] priMask;
    logic openDrain;
    logic globalMask;
    logic alertOut;
    logic alertOen;
    logic [DATA_W-1:0] rdData;
    logic slvErr;
    logic actionOut;
  } tli_ctrl_state_t;

  tli_ctrl_state_t st_q, st_d;

  // ==========================================================
  // bus phases and address decode
  logic setupPh, accessPh, wrEn;
  logic [IDX_W-1:0] word;
  logic hitPri, hitCfg, hitPmask, hitAny;
  logic [NUM_PRI-1:0] hitSecF, hitSecM;
  logic [REG_W-1:0] laneMask;

  assign setupPh = psel && !penable;
  assign accessPh = psel && penable;
  // zero wait states, but a frozen clock also stalls the bus
  assign pready = accessPh && ce;
  assign wrEn = accessPh && ce && pwrite;
  assign word = paddr[PADDR_W-1:2];
  assign hitPri = (word == IDX_PRI_STATUS);
  assign hitCfg = (word == IDX_ALERT_CFG);
  assign hitPmask = (word == IDX_PRI_MASK);
  assign hitAny = hitPri || hitCfg || hitPmask || (|hitSecF) || (|hitSecM);
  // registers are 16 bits, only the two low lanes count
  assign laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // ==========================================================
  // secondary groups
  logic [SEC_W-1:0] evtArr [NUM_PRI];
  logic [SEC_W-1:0] secFlags [NUM_PRI];
  logic [SEC_W-1:0] secMask [NUM_PRI];
  logic [REG_W-1:0] secRd [NUM_PRI];
  logic [NUM_PRI-1:0] priFlags;

  assign evtArr[0] = powerStateEvt;
  assign evtArr[1] = thermalEvt;
  assign evtArr[2] = gpioEvt;
  assign evtArr[3] = onPinEvt;
  assign evtArr[4] = watchdogEvt;
  assign evtArr[5] = auxConverterEvt;
  assign evtArr[6] = powerPathEvt;

  for (genvar g = 0; g < NUM_PRI; g++) begin : gGroup
    logic clrWe, maskWe;
    assign hitSecF[g] = (word == IDX_W'(IDX_SEC_FLAG_BASE + IDX_W'(g)));
    assign hitSecM[g] = (word == IDX_W'(IDX_SEC_MASK_BASE + IDX_W'(g)));
    // only a write clears, a read leaves every flag alone
    assign clrWe = wrEn && hitSecF[g];
    assign maskWe = wrEn && hitSecM[g];
    // flags and masks read back in the low bits
    assign secRd[g] = hitSecF[g] ? REG_W'(secFlags[g]) :
                      hitSecM[g] ? REG_W'(secMask[g]) : 16'h0000;
    tli_sec_group uGroup (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .eventIn(evtArr[g]),
      .clrWe(clrWe),
      .clrData(pwdata[SEC_W-1:0] & laneMask[SEC_W-1:0]),
      .maskWe(maskWe),
      .maskData(pwdata[SEC_W-1:0]),
      .maskLane(laneMask[SEC_W-1:0]),
      .flags(secFlags[g]),
      .mask(secMask[g]),
      .primary(priFlags[g])
    );
  end

  // ==========================================================
  // primary status word, built from live flags so it is always valid
  logic [REG_W-1:0] priWord, pmaskWord, cfgWord, secWord;
  logic alertReq;

  always_comb begin
    priWord = 16'h0000;
    pmaskWord = 16'h0000;
    secWord = 16'h0000;
    for (int i = 0; i < NUM_PRI; i++) begin
      priWord[PRI_POS[i]] = priFlags[i];
      pmaskWord[PRI_POS[i]] = st_q.priMask[i];
      secWord = secWord | secRd[i];
    end
    cfgWord = 16'h0000;
    cfgWord[CFG_OD_BIT] = st_q.openDrain;
    cfgWord[CFG_GMASK_BIT] = st_q.globalMask;
    cfgWord[CFG_PIN_BIT] = alertPinIn;
  end

  // primary flags ignore their alert masks; the masks only gate here
  assign alertReq = (|(priFlags & ~st_q.priMask)) && !st_q.globalMask;

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    if (ce) begin
      // read data and error are caught in setup so they come from flops
      if (setupPh) begin
        st_d.slvErr = !hitAny;
        st_d.rdData = RDATA_RST;
        if (!pwrite) begin
          st_d.rdData[REG_W-1:0] = (hitPri ? priWord : 16'h0000) |
                                   (hitCfg ? cfgWord : 16'h0000) |
                                   (hitPmask ? pmaskWord : 16'h0000) |
                                   secWord;
        end
      end
      // the status word has no write path at all
      if (wrEn && hitCfg) begin
        if (pstrb[0]) begin
          st_d.openDrain = pwdata[CFG_OD_BIT];
          st_d.globalMask = pwdata[CFG_GMASK_BIT];
        end
      end
      if (wrEn && hitPmask) begin
        for (int i = 0; i < NUM_PRI; i++) begin
          if (laneMask[PRI_POS[i]]) begin
            st_d.priMask[i] = pwdata[PRI_POS[i]];
          end
        end
      end
      // open drain releases instead of driving high
      if (st_q.openDrain) begin
        st_d.alertOut = 1'b0;
        st_d.alertOen = !alertReq;
      end else begin
        st_d.alertOut = !alertReq;
        st_d.alertOen = 1'b0;
      end
      // actions pass with no mask in the path
      st_d.actionOut = actionReq;
    end
  end

  // single clock, defaults on reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q.priMask <= PRI_MASK_RST;
      st_q.openDrain <= CFG_OD_RST;
      st_q.globalMask <= CFG_GMASK_RST;
      st_q.alertOut <= ALERT_OUT_RST;
      st_q.alertOen <= ALERT_OEN_RST;
      st_q.rdData <= RDATA_RST;
      st_q.slvErr <= 1'b0;
      st_q.actionOut <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = st_q.rdData;
  assign pslverr = pready && st_q.slvErr;
  assign alertOut = st_q.alertOut;
  assign alertOen = st_q.alertOen;
  assign actionOut = st_q.actionOut;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic noEvt;
  assign noEvt = (powerStateEvt | thermalEvt | gpioEvt | onPinEvt |
                  watchdogEvt | auxConverterEvt | powerPathEvt) == 4'h0;

  sequence priWrite;
    wrEn && hitPri && noEvt;
  endsequence

  status_ro_a: assert property (priWrite |=> $stable(priFlags) &&
    $stable(st_q.priMask) && $stable(st_q.openDrain))
    else $error("write to status word changed state");
  alert_low_a: assert property (ce && alertReq && !st_q.openDrain |=>
    alertOut == 1'b0 && alertOen == 1'b0)
    else $error("alert not driven low");
  alert_idle_a: assert property (ce && !alertReq |=>
    (alertOut == 1'b1 && alertOen == 1'b0) || (alertOen == 1'b1))
    else $error("alert asserted with no cause");
  od_mode_a: assert property (ce && st_q.openDrain |=>
    alertOut == 1'b0 && alertOen == !$past(alertReq))
    else $error("open drain drive wrong");
  gmask_hold_a: assert property (ce && st_q.globalMask |=>
    !(alertOut == 1'b0 && alertOen == 1'b0))
    else $error("masked alert pulled low");
  pmask_rst_a: assert property ($rose(resetn) |->
    st_q.priMask == PRI_MASK_RST)
    else $error("primary masks not set after reset");
  pmask_gate_a: assert property (ce && (priFlags & ~st_q.priMask) == 7'h00 |=>
    !(alertOut == 1'b0 && alertOen == 1'b0))
    else $error("masked primary drove the alert");
  cfg_write_a: assert property (wrEn && hitCfg && pstrb[0] |=>
    st_q.openDrain == $past(pwdata[CFG_OD_BIT]) &&
    st_q.globalMask == $past(pwdata[CFG_GMASK_BIT]))
    else $error("config write not stored");
  action_pass_a: assert property (ce |=> actionOut == $past(actionReq))
    else $error("action not passed through");
endmodule // tli_ctrl
`default_nettype wire

// >>> tb/tli_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module tli_host_model
  import tli_pkg::*;
(
  // clock
  input wire logic clk,
  // apb master outputs
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [PADDR_W-1:0] paddr,
  output logic [DATA_W-1:0] pwdata,
  output logic [3:0] pstrb,
  // apb slave answer
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [DATA_W-1:0] prdata
);
  // ==========================================================
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
  end
  // one transfer; request held until pready seen high at an edge
  task xfer(input logic wr, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd,
            output logic [DATA_W-1:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= 4'hf;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // alert handler: status first, then each flagged group, then write ones back
  task service();
    logic [DATA_W-1:0] st;
    logic [DATA_W-1:0] fl;
    logic e;
    xfer(1'b0, IDX_PRI_STATUS, '0, st, e);
    for (int g = 0; g < NUM_PRI; g++) begin
      if (st[PRI_POS[g]]) begin
        xfer(1'b0, IDX_SEC_FLAG_BASE + IDX_W'(g), '0, fl, e);
        xfer(1'b1, IDX_SEC_FLAG_BASE + IDX_W'(g), fl, st, e);
        xfer(1'b0, IDX_PRI_STATUS, '0, st, e);
      end
    end
  endtask
endmodule // tli_host_model
`default_nettype wire

// >>> tb/tb_two_level_interrupt_controller.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin errCount++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_two_level_interrupt_controller
  import tli_pkg::*;
;
  typedef struct {int grp; logic [SEC_W-1:0] bits; logic [15:0] stat;} tli_row_t;
  // ==========================================================
  // signals
  logic clk, resetn, ce, actionReq, actionOut, alertOut, alertOen, errv;
  logic psel, penable, pwrite, pready, pslverr;
  logic [PADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rdv;
  logic [3:0] pstrb;
  logic [SEC_W-1:0] evt [NUM_PRI];
  int errCount = 0;
  int totalChecks = 0;
  wire logic pinLevel = alertOen ? 1'b1 : alertOut; // released pin rides the pull-up
  tli_row_t rows [NUM_PRI] = '{'{0, 4'h1, 16'h8000}, '{1, 4'h2, 16'h4000},
    '{2, 4'h4, 16'h2000}, '{3, 4'h8, 16'h1000}, '{4, 4'h3, 16'h0800},
    '{5, 4'h5, 16'h0100}, '{6, 4'hf, 16'h0080}};
  // ==========================================================
  // clock, design and host
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  tli_ctrl dut (.clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .powerStateEvt(evt[0]), .thermalEvt(evt[1]),
    .gpioEvt(evt[2]), .onPinEvt(evt[3]), .watchdogEvt(evt[4]), .auxConverterEvt(evt[5]),
    .powerPathEvt(evt[6]), .actionReq(actionReq), .actionOut(actionOut),
    .alertPinIn(pinLevel), .alertOut(alertOut), .alertOen(alertOen));
  tli_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata));
  // ==========================================================
  // helpers
  function automatic logic [IDX_W-1:0] fIdx(int g);
    return IDX_SEC_FLAG_BASE + IDX_W'(g);
  endfunction
  task rd(input logic [IDX_W-1:0] idx);
    host.xfer(1'b0, idx, '0, rdv, errv);
  endtask
  task wr(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d);
    host.xfer(1'b1, idx, d, rdv, errv);
  endtask
  // one-cycle event, then room for flag and pin to settle
  task pulse(input int g, input logic [SEC_W-1:0] b);
    evt[g] <= b;
    @(posedge clk);
    evt[g] <= '0;
    repeat (3) @(posedge clk);
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    errCount++;
    complete_run();
  end
  // ==========================================================
  // main sequence
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    actionReq = 1'b0;
    for (int g = 0; g < NUM_PRI; g++) evt[g] = '0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(IDX_PRI_MASK); `CHK(rdv[15:0], 16'hf980)
    rd(IDX_ALERT_CFG); `CHK(rdv[2:0], 3'h4)
    rd(18'h00000); `CHK({errv, rdv}, {1'b1, 32'h0}) // unmapped place refused
    // a frozen clock enable must not latch an event
    ce <= 1'b0; evt[1] <= 4'h1; @(posedge clk); evt[1] <= '0; ce <= 1'b1;
    rd(fIdx(1)); `CHK({errv, rdv[3:0]}, 5'h00)
    // table rows: one group each, latch, read, clear
    foreach (rows[i]) begin
      pulse(rows[i].grp, rows[i].bits);
      rd(IDX_PRI_STATUS); `CHK(rdv[15:0], rows[i].stat)
      `CHK(pinLevel, 1'b1)
      rd(fIdx(rows[i].grp)); `CHK(rdv[3:0], rows[i].bits)
      rd(fIdx(rows[i].grp)); `CHK(rdv[3:0], rows[i].bits)
      wr(fIdx(rows[i].grp), 32'h0); rd(fIdx(rows[i].grp)); `CHK(rdv[3:0], rows[i].bits)
      wr(fIdx(rows[i].grp), {28'h0, rows[i].bits}); rd(fIdx(rows[i].grp)); `CHK(rdv[3:0], 4'h0)
      rd(IDX_PRI_STATUS); `CHK(rdv[15:0], 16'h0)
    end
    // alert path through both mask levels and both drive types
    wr(IDX_PRI_MASK, 32'h0); pulse(2, 4'h1);
    `CHK({alertOen, alertOut, pinLevel}, 3'b000)
    wr(IDX_PRI_STATUS, 32'h0); rd(IDX_PRI_STATUS); `CHK(rdv[15:0], 16'h2000)
    wr(IDX_PRI_MASK, 32'h2000); repeat (2) @(posedge clk); `CHK(pinLevel, 1'b1)
    rd(IDX_PRI_STATUS); `CHK(rdv[15:0], 16'h2000)
    wr(IDX_PRI_MASK, 32'h0); wr(IDX_ALERT_CFG, 32'h2); repeat (2) @(posedge clk);
    `CHK({alertOen, alertOut}, 2'b00)
    wr(IDX_ALERT_CFG, 32'h3); repeat (2) @(posedge clk); `CHK({alertOen, pinLevel}, 2'b11)
    wr(IDX_ALERT_CFG, 32'h1); repeat (2) @(posedge clk); `CHK({alertOen, alertOut}, 2'b01)
    wr(IDX_ALERT_CFG, 32'h0);
    // secondary mask hides one flag while an unmasked flag of the group still latches
    wr(IDX_SEC_MASK_BASE + 18'h2, 32'h1); rd(IDX_PRI_STATUS); `CHK(rdv[15:0], 16'h0)
    pulse(2, 4'h2); rd(fIdx(2)); `CHK(rdv[3:0], 4'h3)
    rd(IDX_PRI_STATUS); `CHK(rdv[15:0], 16'h2000)
    // event lands on the very edge that clears it
    fork
      wr(fIdx(2), 32'h3);
      begin
        repeat (2) @(posedge clk);
        evt[2] <= 4'h1;
        @(posedge clk);
        evt[2] <= '0;
      end
    join
    rd(fIdx(2)); `CHK(rdv[3:0], 4'h1)
    wr(IDX_SEC_MASK_BASE + 18'h2, 32'h0); host.service(); repeat (2) @(posedge clk);
    rd(IDX_PRI_STATUS); `CHK({rdv[15:0], pinLevel}, 17'h00001)
    // side action ignores every mask
    wr(IDX_ALERT_CFG, 32'h1); wr(IDX_PRI_MASK, 32'hffff);
    actionReq <= 1'b1; repeat (2) @(posedge clk); `CHK(actionOut, 1'b1)
    actionReq <= 1'b0; repeat (2) @(posedge clk); `CHK(actionOut, 1'b0)
    // second reset in mid-run
    pulse(0, 4'h1); resetn <= 1'b0; repeat (2) @(posedge clk); resetn <= 1'b1;
    rd(fIdx(0)); `CHK(rdv[3:0], 4'h0)
    rd(IDX_PRI_MASK); `CHK(rdv[15:0], 16'hf980)
    rd(IDX_ALERT_CFG); `CHK(rdv[2:0], 3'h4)
    complete_run();
  end
endmodule // tb_two_level_interrupt_controller
`default_nettype wire
